// *** include/odr_params.svh ***
// constants for the output driver routing control block
// assumes inclusion by bare name from every design file that needs it
`ifndef ODR_PARAMS_SVH
`define ODR_PARAMS_SVH

// ==========================================================
// register addresses, pair control
`define ODR_ADDR_PAIR_0A    16'h10d7
`define ODR_ADDR_PAIR_0B    16'h10d8
`define ODR_ADDR_PAIR_0C    16'h10d9
`define ODR_ADDR_PAIR_1A    16'h14d7
`define ODR_ADDR_PAIR_1B    16'h14d8

// ==========================================================
// register addresses, divider ratios and pin status
`define ODR_ADDR_PRI_DIV0   16'h2000
`define ODR_ADDR_SEC_DIV0   16'h2010
`define ODR_ADDR_POS_STAT   16'h2020
`define ODR_ADDR_NEG_STAT   16'h2021

// ==========================================================
// field layout of a pair control register
`define ODR_DIR_BIT         0
`define ODR_MAG_LSB         1
`define ODR_MAG_MSB         2
`define ODR_MODE_LSB        3
`define ODR_MODE_MSB        4
`define ODR_CTRL_USED_MSB   4

// ==========================================================
// reset values and the field code that writes ignore
`define ODR_CTRL_RESET      5'h00
`define ODR_DIV_RESET       8'h01
`define ODR_INVALID_CODE    2'h3

// ==========================================================
// driver current in half milliamp units
`define ODR_CUR_OFF         8'h00
`define ODR_CUR_7P5         8'h0f
`define ODR_CUR_12P5        8'h19
`define ODR_CUR_15          8'h1e

`endif

// *** include/odr_pkg.sv ***
// types shared by the output driver routing control block
// assumes odr_params.svh supplies all numeric constants
package odr_pkg;

  typedef enum logic [1:0] {
    ODR_MODE_DIFF = 2'h0,
    ODR_MODE_SE   = 2'h1,
    ODR_MODE_DUAL = 2'h2,
    ODR_MODE_BAD  = 2'h3
  } odr_mode_t;

  typedef enum logic [1:0] {
    ODR_MAG_7P5  = 2'h0,
    ODR_MAG_12P5 = 2'h1,
    ODR_MAG_15   = 2'h2,
    ODR_MAG_BAD  = 2'h3
  } odr_mag_t;

endpackage : odr_pkg

// *** src/odr_chan_div.sv ***
// one channel divider: toggles its output every ratio source edges
// assumes src_rise_in is a one-cycle pulse on the block clock
`timescale 1ns/1ps
module odr_chan_div #(
  parameter int DIV_W = 8
) (
  input  wire logic             clock_in,
  input  wire logic             rst_n_in,
  input  wire logic             power_up_in,
  input  wire logic             src_rise_in,
  input  wire logic [DIV_W-1:0] ratio_in,
  output logic                  q_out
);

  logic [DIV_W-1:0] count_r;
  logic [DIV_W-1:0] limit;

  initial begin
    if (DIV_W < 1) begin
      $error("odr_chan_div: DIV_W must be at least 1");
    end
  end

  // a zero ratio behaves as one so the divider never stalls
  assign limit = (ratio_in == '0) ? DIV_W'(1) : ratio_in;

  // ==========================================================
  // edge counter
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_r <= '0;
    end else if (!power_up_in) begin
      count_r <= '0;
    end else if (src_rise_in) begin
      if (count_r + DIV_W'(1) >= limit) begin
        count_r <= '0;
      end else begin
        count_r <= count_r + DIV_W'(1);
      end
    end
  end

  // ==========================================================
  // output level, held low while powered down
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q_out <= 1'b0;
    end else if (!power_up_in) begin
      q_out <= 1'b0;
    end else if (src_rise_in && (count_r + DIV_W'(1) >= limit)) begin
      q_out <= ~q_out;
    end
  end

endmodule : odr_chan_div

// *** src/odr_pair_route.sv ***
// routing of one pin pair: dividers to drivers and driver currents
// purely combinational; the caller registers the results
`timescale 1ns/1ps
`include "odr_params.svh"
module odr_pair_route (
  input  wire logic              pri_q_in,
  input  wire logic              sec_q_in,
  input  wire odr_pkg::odr_mode_t mode_in,
  input  wire odr_pkg::odr_mag_t  mag_in,
  output logic                   pos_on_out,
  output logic                   neg_on_out,
  output logic [7:0]             pos_cur_out,
  output logic [7:0]             neg_cur_out
);
  import odr_pkg::*;

  logic [7:0] level;

  // ==========================================================
  // divider to driver connectivity
  always_comb begin
    pos_on_out = pri_q_in;
    neg_on_out = 1'b0;
    case (mode_in)
      ODR_MODE_DIFF: neg_on_out = ~pri_q_in; // RULE7 RULE11
      ODR_MODE_SE:   neg_on_out = pri_q_in;  // RULE8
      ODR_MODE_DUAL: neg_on_out = sec_q_in;  // RULE9
      default:       neg_on_out = ~pri_q_in;
    endcase
  end

  // ==========================================================
  // programmed magnitude
  always_comb begin
    case (mag_in)
      ODR_MAG_7P5:  level = `ODR_CUR_7P5;  // RULE4
      ODR_MAG_12P5: level = `ODR_CUR_12P5; // RULE4
      ODR_MAG_15:   level = `ODR_CUR_15;   // RULE4
      default:      level = `ODR_CUR_7P5;
    endcase
  end

  // current flows only while the pin's own on level is high
  assign pos_cur_out = pos_on_out ? level : `ODR_CUR_OFF; // RULE10
  assign neg_cur_out = neg_on_out ? level : `ODR_CUR_OFF; // RULE10

endmodule : odr_pair_route

// *** src/odr_ctrl.sv ***
// top of the output driver routing control: five pin pairs in two groups
// assumes synth channel clocks arrive asynchronously and are far slower
// than clock_in; the register master follows the one-cycle strobe port
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "odr_params.svh"

//
// Operation
// RULE1 - group zero from first, group one second
// RULE2 - one control register per pin pair
// RULE3 - bit 0 picks sink or source
// RULE4 - magnitude code picks 7.5, 12.5, 15 mA
// RULE5 - mode code picks divider to driver routing
// RULE6 - single modes power down secondary divider
// RULE7 - differential: negative pin is inverted positive
// RULE8 - single-ended: both pins carry primary in phase
// RULE9 - dual: primary positive, secondary negative pin
// RULE10 - current off when divider low, programmed high
// RULE11 - primary true and complement make differential pair
// RULE12 - host programs HCSL as diff, source, 15mA
module odr_ctrl #(
  parameter int N_PAIRS_G0 = 3,
  parameter int N_PAIRS_G1 = 2,
  parameter int DIV_W      = 8
) (
  input  wire logic        clock_in,
  input  wire logic        rst_n_in,
  input  wire logic [15:0] addr_in,
  input  wire logic [7:0]  wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [7:0]  rdata_out,
  input  wire logic        first_synth_channel_in,
  input  wire logic        second_synth_channel_in,
  output logic      [4:0]  positive_output_pin_on_out,
  output logic      [4:0]  negative_output_pin_on_out,
  output logic      [39:0] positive_output_pin_cur_out,
  output logic      [39:0] negative_output_pin_cur_out,
  output logic      [4:0]  pair_source_out
);
  import odr_pkg::*;

  localparam int NP = N_PAIRS_G0 + N_PAIRS_G1;

  // ==========================================================
  // elaboration checks
  initial begin
    if (N_PAIRS_G0 != 3 || N_PAIRS_G1 != 2) begin
      $error("odr_ctrl: the address map serves exactly three plus two pairs");
    end
    if (DIV_W < 1 || DIV_W > 8) begin
      $error("odr_ctrl: DIV_W must lie in 1..8 to fit the data port");
    end
  end

  // ==========================================================
  // address table
  logic [15:0] ctrl_addr [NP];
  assign ctrl_addr[0] = `ODR_ADDR_PAIR_0A; // RULE2
  assign ctrl_addr[1] = `ODR_ADDR_PAIR_0B; // RULE2
  assign ctrl_addr[2] = `ODR_ADDR_PAIR_0C; // RULE2
  assign ctrl_addr[3] = `ODR_ADDR_PAIR_1A; // RULE2
  assign ctrl_addr[4] = `ODR_ADDR_PAIR_1B; // RULE2

  // ==========================================================
  // synth channel synchronisers and edge detect
  logic [1:0] ch_meta_r;
  logic [1:0] ch_sync_r;
  logic [1:0] ch_prev_r;
  logic [1:0] ch_rise;

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ch_meta_r <= 2'h0;
      ch_sync_r <= 2'h0;
      ch_prev_r <= 2'h0;
    end else begin
      ch_meta_r <= {second_synth_channel_in, first_synth_channel_in};
      ch_sync_r <= ch_meta_r;
      ch_prev_r <= ch_sync_r;
    end
  end

  assign ch_rise = ch_sync_r & ~ch_prev_r;

  // ==========================================================
  // register storage
  logic [`ODR_CTRL_USED_MSB:0] ctrl_r    [NP];
  logic [DIV_W-1:0]            pri_div_r [NP];
  logic [DIV_W-1:0]            sec_div_r [NP];
  logic [NP-1:0]               hit_ctrl;
  logic [NP-1:0]               hit_pri;
  logic [NP-1:0]               hit_sec;

  genvar gi;
  generate
    for (gi = 0; gi < NP; gi++) begin : g_dec
      assign hit_ctrl[gi] = (addr_in == ctrl_addr[gi]);
      assign hit_pri[gi]  = (addr_in == (`ODR_ADDR_PRI_DIV0 + 16'(gi)));
      assign hit_sec[gi]  = (addr_in == (`ODR_ADDR_SEC_DIV0 + 16'(gi)));
    end
  endgenerate

  generate
    for (gi = 0; gi < NP; gi++) begin : g_regs
      logic [1:0] wr_mag;
      logic [1:0] wr_mode;
      assign wr_mag  = wdata_in[`ODR_MAG_MSB:`ODR_MAG_LSB];
      assign wr_mode = wdata_in[`ODR_MODE_MSB:`ODR_MODE_LSB];

      // direction bit written as given
      always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          ctrl_r[gi][`ODR_DIR_BIT] <= 1'(`ODR_CTRL_RESET >> `ODR_DIR_BIT); // RULE3
        end else if (wr_in && hit_ctrl[gi]) begin
          ctrl_r[gi][`ODR_DIR_BIT] <= wdata_in[`ODR_DIR_BIT]; // RULE3
        end
      end

      // an unusable magnitude code leaves the previous setting in place
      always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          ctrl_r[gi][`ODR_MAG_MSB:`ODR_MAG_LSB] <= 2'(`ODR_CTRL_RESET >> `ODR_MAG_LSB); // RULE4
        end else if (wr_in && hit_ctrl[gi] && wr_mag != `ODR_INVALID_CODE) begin
          ctrl_r[gi][`ODR_MAG_MSB:`ODR_MAG_LSB] <= wr_mag; // RULE4
        end
      end

      // same for the mode field, so routing never enters an undefined state
      always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          ctrl_r[gi][`ODR_MODE_MSB:`ODR_MODE_LSB] <= 2'(`ODR_CTRL_RESET >> `ODR_MODE_LSB); // RULE5
        end else if (wr_in && hit_ctrl[gi] && wr_mode != `ODR_INVALID_CODE) begin
          ctrl_r[gi][`ODR_MODE_MSB:`ODR_MODE_LSB] <= wr_mode; // RULE5
        end
      end

      always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          pri_div_r[gi] <= DIV_W'(`ODR_DIV_RESET);
        end else if (wr_in && hit_pri[gi]) begin
          pri_div_r[gi] <= wdata_in[DIV_W-1:0];
        end
      end

      always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          sec_div_r[gi] <= DIV_W'(`ODR_DIV_RESET);
        end else if (wr_in && hit_sec[gi]) begin
          sec_div_r[gi] <= wdata_in[DIV_W-1:0];
        end
      end
    end
  endgenerate

  // ==========================================================
  // dividers and routing per pair
  logic [NP-1:0] pri_q;
  logic [NP-1:0] sec_q;
  logic [NP-1:0] pos_on;
  logic [NP-1:0] neg_on;
  logic [7:0]    pos_cur [NP];
  logic [7:0]    neg_cur [NP];

  generate
    for (gi = 0; gi < NP; gi++) begin : g_pair
      odr_mode_t mode;
      odr_mag_t  mag;
      logic      src_rise;
      logic      sec_up;

      assign mode = odr_mode_t'(ctrl_r[gi][`ODR_MODE_MSB:`ODR_MODE_LSB]);
      assign mag  = odr_mag_t'(ctrl_r[gi][`ODR_MAG_MSB:`ODR_MAG_LSB]);
      // pairs below the group boundary see only the first channel
      assign src_rise = (gi < N_PAIRS_G0) ? ch_rise[0] : ch_rise[1]; // RULE1
      assign sec_up   = (mode == ODR_MODE_DUAL); // RULE6

      odr_chan_div #(
        .DIV_W (DIV_W)
      ) u_pri_div (
        .clock_in    (clock_in),
        .rst_n_in    (rst_n_in),
        .power_up_in (1'b1),
        .src_rise_in (src_rise),
        .ratio_in    (pri_div_r[gi]),
        .q_out       (pri_q[gi])
      );

      odr_chan_div #(
        .DIV_W (DIV_W)
      ) u_sec_div (
        .clock_in    (clock_in),
        .rst_n_in    (rst_n_in),
        .power_up_in (sec_up),
        .src_rise_in (src_rise),
        .ratio_in    (sec_div_r[gi]),
        .q_out       (sec_q[gi])
      );

      odr_pair_route u_route (
        .pri_q_in    (pri_q[gi]),
        .sec_q_in    (sec_q[gi]),
        .mode_in     (mode),
        .mag_in      (mag),
        .pos_on_out  (pos_on[gi]),
        .neg_on_out  (neg_on[gi]),
        .pos_cur_out (pos_cur[gi]),
        .neg_cur_out (neg_cur[gi])
      );
    end
  endgenerate

  // ==========================================================
  // registered pin outputs
  generate
    for (gi = 0; gi < NP; gi++) begin : g_out
      always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          positive_output_pin_on_out[gi]           <= 1'b0;
          negative_output_pin_on_out[gi]           <= 1'b0;
          positive_output_pin_cur_out[gi*8 +: 8]   <= `ODR_CUR_OFF;
          negative_output_pin_cur_out[gi*8 +: 8]   <= `ODR_CUR_OFF;
          pair_source_out[gi]                      <= 1'b0;
        end else begin
          positive_output_pin_on_out[gi]           <= pos_on[gi];  // RULE10
          negative_output_pin_on_out[gi]           <= neg_on[gi];  // RULE10
          positive_output_pin_cur_out[gi*8 +: 8]   <= pos_cur[gi]; // RULE10
          negative_output_pin_cur_out[gi*8 +: 8]   <= neg_cur[gi]; // RULE10
          pair_source_out[gi]                      <= ctrl_r[gi][`ODR_DIR_BIT]; // RULE3
        end
      end
    end
  endgenerate

  // ==========================================================
  // read path, data valid only in the cycle after the strobe
  logic [7:0] rd_mux;

  always_comb begin
    rd_mux = 8'h00;
    for (int i = 0; i < NP; i++) begin
      if (hit_ctrl[i]) begin
        rd_mux = 8'(ctrl_r[i]); // RULE2
      end
      if (hit_pri[i]) begin
        rd_mux = 8'(pri_div_r[i]);
      end
      if (hit_sec[i]) begin
        rd_mux = 8'(sec_div_r[i]);
      end
    end
    if (addr_in == `ODR_ADDR_POS_STAT) begin
      rd_mux = 8'(positive_output_pin_on_out);
    end
    if (addr_in == `ODR_ADDR_NEG_STAT) begin
      rd_mux = 8'(negative_output_pin_on_out);
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_out <= 8'h00;
    end else if (rd_in) begin
      rdata_out <= rd_mux;
    end else begin
      rdata_out <= 8'h00;
    end
  end

endmodule : odr_ctrl

// *** sim/odr_ctrl_props.sv ***
// checker for odr_ctrl: shadows the pair 0A control and watches pins and reads
// assumes it is bound to odr_ctrl and sees only its ports
`timescale 1ns/1ps
module odr_ctrl_props (
  input wire logic        clock_in,
  input wire logic        rst_n_in,
  input wire logic [15:0] addr_in,
  input wire logic [7:0]  wdata_in,
  input wire logic        wr_in,
  input wire logic        rd_in,
  input wire logic [7:0]  rdata_out,
  input wire logic        first_synth_channel_in,
  input wire logic        second_synth_channel_in,
  input wire logic [4:0]  positive_output_pin_on_out,
  input wire logic [4:0]  negative_output_pin_on_out,
  input wire logic [39:0] positive_output_pin_cur_out,
  input wire logic [39:0] negative_output_pin_cur_out,
  input wire logic [4:0]  pair_source_out
);
  import odr_pkg::*;
  logic       dir_r;
  logic [1:0] mag_r;
  logic [1:0] mode_r;
  logic       held_r;
  logic       ch1_r;
  logic [3:0] quiet_r;
  // ==========================================================
  // shadow state; code 3 leaves a field as it was
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dir_r  <= 1'b0;
      mag_r  <= 2'h0;
      mode_r <= 2'h0;
    end else if (wr_in && addr_in == 16'h10d7) begin
      dir_r <= wdata_in[0];
      if (wdata_in[2:1] != 2'h3) mag_r <= wdata_in[2:1];
      if (wdata_in[4:3] != 2'h3) mode_r <= wdata_in[4:3];
    end
  end
  // pins lag a write by two edges and a channel edge by four
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      held_r  <= 1'b0;
      ch1_r   <= 1'b0;
      quiet_r <= 4'h0;
    end else begin
      held_r <= !wr_in;
      ch1_r  <= second_synth_channel_in;
      if (ch1_r != second_synth_channel_in) quiet_r <= 4'h0;
      else if (quiet_r != 4'hf) quiet_r <= quiet_r + 4'h1;
    end
  end
  function automatic logic [7:0] lvl(input logic [1:0] m);
    lvl = (m == 2'h1) ? 8'h19 : (m == 2'h2) ? 8'h1e : 8'h0f;
  endfunction : lvl
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_rd_pair0;
    rd_in && addr_in == 16'h10d7;
  endsequence
  a_cur_off_idle: assert property (!positive_output_pin_on_out[0] |->
    positive_output_pin_cur_out[7:0] == 8'h00) else $error("current while pin off");
  a_cur_on_level: assert property (held_r && positive_output_pin_on_out[0] |->
    positive_output_pin_cur_out[7:0] == lvl(mag_r)) else $error("wrong drive level");
  a_diff_complement: assert property (held_r && mode_r == ODR_MODE_DIFF |->
    positive_output_pin_on_out[0] != negative_output_pin_on_out[0]) else $error("not diff");
  a_se_in_phase: assert property (held_r && mode_r == ODR_MODE_SE |->
    positive_output_pin_on_out[0] == negative_output_pin_on_out[0] &&
    positive_output_pin_cur_out[7:0] == negative_output_pin_cur_out[7:0])
    else $error("pins not in phase");
  a_source_follows: assert property (held_r |-> pair_source_out[0] == dir_r)
    else $error("wrong current direction");
  a_read_pair0: assert property (s_rd_pair0 |=>
    rdata_out == {3'h0, mode_r, mag_r, dir_r}) else $error("wrong control readback");
  a_read_idle_zero: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
    else $error("read data outside its cycle");
  a_group_one_isolated: assert property (quiet_r >= 4'h6 && held_r && $past(held_r) |->
    $stable(positive_output_pin_on_out[4:3]) && $stable(negative_output_pin_on_out[4:3]))
    else $error("group one moved without its channel");
endmodule : odr_ctrl_props

bind odr_ctrl odr_ctrl_props u_props (.clock_in, .rst_n_in, .addr_in, .wdata_in, .wr_in,
  .rd_in, .rdata_out, .first_synth_channel_in, .second_synth_channel_in,
  .positive_output_pin_on_out, .negative_output_pin_on_out, .positive_output_pin_cur_out,
  .negative_output_pin_cur_out, .pair_source_out);

// *** sim/odr_rx_model.sv ***
// clock receiver model: counts rising edges seen on every pin of the five pairs
// assumes pin levels are sampled on the block clock
`timescale 1ns/1ps
module odr_rx_model (
  input  wire logic        clock_in,
  input  wire logic        rst_n_in,
  input  wire logic        clear_in,
  input  wire logic [4:0]  pos_on_in,
  input  wire logic [4:0]  neg_on_in,
  input  wire logic [39:0] pos_cur_in,
  input  wire logic [39:0] neg_cur_in,
  input  wire logic [4:0]  source_in,
  output logic      [39:0] pos_cnt_out,
  output logic      [39:0] neg_cnt_out,
  output logic             hcsl_ok_out
);
  logic [4:0] pos_q_r;
  logic [4:0] neg_q_r;
  // ==========================================================
  // edge counters, eight bits a pin
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pos_q_r     <= 5'h00;
      neg_q_r     <= 5'h00;
      pos_cnt_out <= 40'h0;
      neg_cnt_out <= 40'h0;
    end else begin
      pos_q_r <= pos_on_in;
      neg_q_r <= neg_on_in;
      for (int i = 0; i < 5; i++) begin
        pos_cnt_out[8*i +: 8] <= clear_in ? 8'h00 :
          pos_cnt_out[8*i +: 8] + {7'h0, pos_on_in[i] & ~pos_q_r[i]};
        neg_cnt_out[8*i +: 8] <= clear_in ? 8'h00 :
          neg_cnt_out[8*i +: 8] + {7'h0, neg_on_in[i] & ~neg_q_r[i]};
      end
    end
  end
  // an hcsl load on pair 0A wants sourced 15 mA
  assign hcsl_ok_out = source_in[0] && (pos_cur_in[7:0] | neg_cur_in[7:0]) == 8'h1e;
endmodule : odr_rx_model

// *** sim/odr_ctrl_tb.sv ***
// testbench for odr_ctrl with a receiver model on the pins
// assumes the one-cycle strobe register port and 125 MHz clock
`timescale 1ns/1ps
module odr_ctrl_tb;
  import odr_pkg::*;
  localparam logic [7:0] LVL [3] = '{8'h0f, 8'h19, 8'h1e};
  logic        clock_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic [15:0] addr_in = 16'h0;
  logic [7:0]  wdata_in = 8'h00;
  logic        wr_in = 1'b0;
  logic        rd_in = 1'b0;
  logic        first_synth_channel_in = 1'b0;
  logic        second_synth_channel_in = 1'b0;
  logic        rx_clear = 1'b0;
  logic        q0 = 1'b0;
  wire  [7:0]  rdata_out;
  wire  [4:0]  positive_output_pin_on_out, negative_output_pin_on_out, pair_source_out;
  wire  [39:0] positive_output_pin_cur_out, negative_output_pin_cur_out, pcnt, ncnt;
  wire         hok;
  int          err_count = 0;
  int          cmp_count = 0;
  always #4 clock_in = ~clock_in;
  odr_ctrl dut (.clock_in, .rst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
    .first_synth_channel_in, .second_synth_channel_in, .positive_output_pin_on_out,
    .negative_output_pin_on_out, .positive_output_pin_cur_out,
    .negative_output_pin_cur_out, .pair_source_out);
  odr_rx_model u_rx (.clock_in, .rst_n_in, .clear_in(rx_clear),
    .pos_on_in(positive_output_pin_on_out), .neg_on_in(negative_output_pin_on_out),
    .pos_cur_in(positive_output_pin_cur_out), .neg_cur_in(negative_output_pin_cur_out),
    .source_in(pair_source_out), .pos_cnt_out(pcnt), .neg_cnt_out(ncnt), .hcsl_ok_out(hok));
  // ==========================================================
  // helpers
  task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t ns: %s", $time, what);
    end
  endtask : chk
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge clock_in);
    wr_in <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
    @(posedge clock_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge clock_in);
    rd_in <= 1'b0;
    #1;
    chk({32'h0, rdata_out}, {32'h0, e}, "read data");
  endtask : rd_chk
  task automatic settle();
    repeat (3) @(posedge clock_in);
    #1;
  endtask : settle
  // channel high four cycles and low at least five, above the two-cycle minimum
  task automatic pulse(input bit ch);
    @(posedge clock_in);
    if (ch) second_synth_channel_in <= 1'b1;
    else first_synth_channel_in <= 1'b1;
    if (!ch) q0 = ~q0;
    repeat (4) @(posedge clock_in);
    first_synth_channel_in  <= 1'b0;
    second_synth_channel_in <= 1'b0;
    repeat (5) @(posedge clock_in);
    #1;
  endtask : pulse
  task automatic clear_rx();
    @(posedge clock_in);
    rx_clear <= 1'b1;
    @(posedge clock_in);
    rx_clear <= 1'b0;
  endtask : clear_rx
  task automatic pins(input logic p, input logic n);
    chk({38'h0, positive_output_pin_on_out[0], negative_output_pin_on_out[0]},
      {38'h0, p, n}, "pair 0A pins");
  endtask : pins
  function automatic logic [15:0] addr_of(input int i);
    addr_of = (i < 3) ? 16'h10d7 + 16'(i) : 16'h14d7 + 16'(i - 3);
  endfunction : addr_of
  // ==========================================================
  // scenarios
  task automatic t_reset();
    #1;
    chk({35'h0, negative_output_pin_on_out}, {35'h0, 5'h1f}, "reset neg pins");
    chk(negative_output_pin_cur_out, {5{LVL[0]}}, "reset neg current");
    chk({35'h0, positive_output_pin_on_out | pair_source_out}, 40'h0, "reset sink");
    for (int i = 0; i < 5; i++) rd_chk(addr_of(i), 8'h00);
  endtask : t_reset
  task automatic t_groups();
    clear_rx();
    pulse(1'b1);
    pulse(1'b1);
    chk(pcnt, {8'h01, 8'h01, 24'h0}, "group pos edges");
    chk(ncnt, {8'h01, 8'h01, 24'h0}, "group neg edges");
  endtask : t_groups
  task automatic t_fields();
    for (int m = 0; m < 3; m++) begin
      wr_reg(16'h10d7, {5'h0, 2'(m), 1'b1});
      settle();
      rd_chk(16'h10d7, {5'h0, 2'(m), 1'b1});
      chk({32'h0, positive_output_pin_cur_out[7:0] | negative_output_pin_cur_out[7:0]},
        {32'h0, LVL[m]}, "drive level");
      chk({39'h0, pair_source_out[0]}, 40'h1, "source bit");
    end
    chk({39'h0, hok}, 40'h1, "hcsl setup");
    wr_reg(16'h10d7, 8'h1f);
    wr_reg(16'h10d7, 8'h0e);
    rd_chk(16'h10d7, 8'h0c);
    for (int i = 1; i < 5; i++) wr_reg(addr_of(i), 8'h13);
    for (int i = 1; i < 5; i++) rd_chk(addr_of(i), 8'h13);
    chk({35'h0, pair_source_out}, {35'h0, 5'h1e}, "source per pair");
    wr_reg(16'h3000, 8'hff);
    rd_chk(16'h3000, 8'h00);
    rd_chk(16'h10da, 8'h00);
  endtask : t_fields
  task automatic t_modes();
    wr_reg(16'h10d7, {3'h0, ODR_MODE_SE, ODR_MAG_7P5, 1'b0});
    settle();
    pins(q0, q0);
    pulse(1'b0);
    pins(q0, q0);
    chk(positive_output_pin_cur_out[7:0], negative_output_pin_cur_out[7:0], "se cur");
    wr_reg(16'h10d7, 8'h00);
    settle();
    pins(q0, ~q0);
    pulse(1'b0);
    pins(q0, ~q0);
    wr_reg(16'h2010, 8'h02);
    wr_reg(16'h10d7, {3'h0, ODR_MODE_DUAL, ODR_MAG_7P5, 1'b1});
    settle();
    pins(q0, 1'b0);
    clear_rx();
    repeat (4) pulse(1'b0);
    chk({32'h0, pcnt[7:0]}, 40'h2, "primary edges");
    chk({32'h0, ncnt[7:0]}, 40'h1, "secondary edges");
    pins(q0, 1'b0);
  endtask : t_modes
  task automatic stop_test();
    if (err_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : stop_test
  initial begin
    #200000;
    err_count++;
    stop_test();
  end
  initial begin
    repeat (10) @(posedge clock_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    t_reset();
    t_groups();
    t_fields();
    t_modes();
    stop_test();
  end
endmodule : odr_ctrl_tb
